// [include/ssl_defs.svh]
/*
  Constants of the serial slave link supervisor: register offsets, field
  positions, reset values, fault codes and timing counts.
  Assumes a 100 MHz core clock and a plain strobe register port.
*/
`ifndef SSL_DEFS_SVH
`define SSL_DEFS_SVH

// register offsets
`define SSL_OFS_REPLY_DLY 4'h0
`define SSL_OFS_TIMEOUT 4'h1
`define SSL_OFS_REACTION 4'h2
`define SSL_OFS_WRREPLY 4'h3
`define SSL_OFS_STATUS 4'h4
`define SSL_OFS_MASK 4'h5
`define SSL_OFS_FAULT 4'h6
`define SSL_OFS_CTRL 4'h7

// reset values and clamp limits
`define SSL_RST_REPLY_DLY 8'h05
`define SSL_RST_TIMEOUT 10'h000
`define SSL_RST_REACTION 2'h1
`define SSL_RST_WRREPLY 1'h0
`define SSL_MAX_REPLY_DLY 8'hC8
`define SSL_MAX_TIMEOUT 10'h3E8

// status bit positions
`define SSL_ST_LINKERR 0
`define SSL_ST_TIMEOUT 1
`define SSL_ST_FAULT 2
`define SSL_ST_REPLY 3

// ctrl bit positions
`define SSL_CTRL_CLEAR 0

// fault codes shown on the display
`define SSL_CODE_NONE 16'h0000
`define SSL_CODE_UNDERV 16'hE001
`define SSL_CODE_OV_ACC 16'hE002
`define SSL_CODE_OV_RUN 16'hE003
`define SSL_CODE_OC_ACC 16'hE004
`define SSL_CODE_OC_DEC 16'hE005
`define SSL_CODE_OC_RUN 16'hE006
`define SSL_CODE_MOTOR_OL 16'hE007
`define SSL_CODE_DRIVE_OL 16'hE008
`define SSL_CODE_OV_DEC 16'hE00A
`define SSL_CODE_EXTERN 16'hE00D
`define SSL_CODE_OVERHEAT 16'hE00E
`define SSL_CODE_STORAGE 16'hE00F
`define SSL_CODE_IN_PHASE 16'hE012
`define SSL_CODE_OUT_PHASE 16'hE013
`define SSL_CODE_SENSE 16'hE015
`define SSL_CODE_LEARN 16'hE016
`define SSL_CODE_LINK 16'hE018

// timing: one ms and one tenth second in core clock cycles
`define SSL_CLK_HZ 100000000
`define SSL_MS_NS 1000000
`define SSL_CLK_NS 10
`define SSL_MS_CYCLES (`SSL_MS_NS / `SSL_CLK_NS)
`define SSL_TENTH_MS 100
`define SSL_TENTH_CYCLES (`SSL_TENTH_MS * `SSL_MS_CYCLES)

`endif

// [include/ssl_pkg.sv]
/*
  Types of the serial slave link supervisor.
  Assumes nothing beyond the defs header.
*/
package ssl_pkg;
  typedef enum logic [1:0] {
    REACT_ALARM_COAST,
    REACT_KEEP_RUN,
    REACT_STOP_LINKCMD,
    REACT_STOP_ANY
  } ssl_react_e;

  typedef enum logic [1:0] {
    RPL_IDLE,
    RPL_WAIT,
    RPL_GO
  } ssl_rpl_e;

  // fault sources, index is the priority order (low index wins)
  typedef enum logic [3:0] {
    FLT_UNDERV,
    FLT_OV_ACC,
    FLT_OV_RUN,
    FLT_OV_DEC,
    FLT_OC_ACC,
    FLT_OC_DEC,
    FLT_OC_RUN,
    FLT_MOTOR_OL,
    FLT_DRIVE_OL,
    FLT_STORAGE,
    FLT_EXTERN,
    FLT_OVERHEAT,
    FLT_IN_PHASE,
    FLT_OUT_PHASE,
    FLT_SENSE,
    FLT_LEARN
  } ssl_fault_e;
endpackage

// [rtl/ssl_tick_timer.sv]
/*
  Tick-based down-counter: counts ticks after a start and flags when the
  loaded count of ticks has passed. Makes its own one-cycle tick every TICK_CYCLES core clocks.
*/
`timescale 1ns/1ns
module ssl_tick_timer #(
  parameter int TICK_CYCLES = 100000,
  parameter int CNT_W = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // control
  input wire logic start,
  input wire logic [CNT_W-1:0] load,
  // status
  output logic expired,
  output logic running
);
  localparam int PW = $clog2(TICK_CYCLES + 1);
  logic [PW-1:0] preCnt_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic run_ff;
  logic exp_ff;
  wire tick = (preCnt_ff == PW'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk)
  begin
    if (srst || start)
    begin
      preCnt_ff <= '0;
      cnt_ff <= load;
      run_ff <= start;
      exp_ff <= 1'b0;
    end
    else if (run_ff)
    begin
      preCnt_ff <= tick ? '0 : preCnt_ff + PW'(1);
      if (cnt_ff == '0)
      begin
        run_ff <= 1'b0;
        exp_ff <= 1'b1;
      end
      else if (tick)
        cnt_ff <= cnt_ff - CNT_W'(1);
    end
    else
      exp_ff <= 1'b0;
  end

  assign expired = exp_ff;
  assign running = run_ff;
endmodule // ssl_tick_timer

// [rtl/ssl_fault_coder.sv]
/*
  Priority encoder from fault source lines to the displayed fault code.
  Assumes fault lines are levels, synchronous to the core clock.
*/
`timescale 1ns/1ns
`include "ssl_defs.svh"
module ssl_fault_coder (
  // inputs
  input wire logic [15:0] faultIn,
  input wire logic linkFault,
  // outputs
  output logic [15:0] code,
  output logic any
);
  always_comb
  begin
    code = `SSL_CODE_NONE;
    if (linkFault)
      code = `SSL_CODE_LINK;
    for (int i = 15; i >= 0; i--)
    begin
      if (faultIn[i])
      begin
        case (ssl_pkg::ssl_fault_e'(i))
          ssl_pkg::FLT_UNDERV: code = `SSL_CODE_UNDERV;
          ssl_pkg::FLT_OV_ACC: code = `SSL_CODE_OV_ACC;
          ssl_pkg::FLT_OV_RUN: code = `SSL_CODE_OV_RUN;
          ssl_pkg::FLT_OV_DEC: code = `SSL_CODE_OV_DEC;
          ssl_pkg::FLT_OC_ACC: code = `SSL_CODE_OC_ACC;
          ssl_pkg::FLT_OC_DEC: code = `SSL_CODE_OC_DEC;
          ssl_pkg::FLT_OC_RUN: code = `SSL_CODE_OC_RUN;
          ssl_pkg::FLT_MOTOR_OL: code = `SSL_CODE_MOTOR_OL;
          ssl_pkg::FLT_DRIVE_OL: code = `SSL_CODE_DRIVE_OL;
          ssl_pkg::FLT_STORAGE: code = `SSL_CODE_STORAGE;
          ssl_pkg::FLT_EXTERN: code = `SSL_CODE_EXTERN;
          ssl_pkg::FLT_OVERHEAT: code = `SSL_CODE_OVERHEAT;
          ssl_pkg::FLT_IN_PHASE: code = `SSL_CODE_IN_PHASE;
          ssl_pkg::FLT_OUT_PHASE: code = `SSL_CODE_OUT_PHASE;
          ssl_pkg::FLT_SENSE: code = `SSL_CODE_SENSE;
          ssl_pkg::FLT_LEARN: code = `SSL_CODE_LEARN;
          default: code = `SSL_CODE_NONE;
        endcase
      end
    end
  end

  assign any = linkFault || (faultIn != 16'h0000);
endmodule // ssl_fault_coder

// [rtl/ssl_link_supervisor.sv]
/*
  Serial slave link supervisor: reply timing, link timeout watchdog,
  link error reaction, write reply suppression and fault reporting.
  Assumes a frame decoder that pulses rxDone per received frame and a
  transmitter that waits for replyGo; all inputs synchronous to core_clk.
*/
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`include "ssl_defs.svh"
module ssl_link_supervisor #(
  parameter int MS_CYCLES = `SSL_MS_CYCLES,
  parameter int TENTH_CYCLES = `SSL_TENTH_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // frame decoder side
  input wire logic rxDone,
  input wire logic rxGood,
  input wire logic rxError,
  input wire logic rxIsWrite,
  input wire logic [7:0] rxAddr,
  input wire logic procDone,
  // transmitter side
  output logic replyGo,
  output logic replyDrop,
  // drive control side
  input wire logic runFromLink,
  input wire logic [15:0] faultIn,
  output logic driveEnable,
  output logic stopRequest,
  output logic faultRelay,
  output logic [15:0] faultCode,
  output logic linkAlarm,
  // interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------
  logic [7:0] replyDelay_ff;
  logic [9:0] timeout_ff;
  logic [1:0] reaction_ff;
  logic writeReplyOff_ff;
  logic [3:0] status_ff;
  logic [3:0] mask_ff;
  logic [15:0] rdata_ff;

  wire selDelay = (regAddr == `SSL_OFS_REPLY_DLY);
  wire selTimeout = (regAddr == `SSL_OFS_TIMEOUT);
  wire selReact = (regAddr == `SSL_OFS_REACTION);
  wire selWrRep = (regAddr == `SSL_OFS_WRREPLY);
  wire selStatus = (regAddr == `SSL_OFS_STATUS);
  wire selMask = (regAddr == `SSL_OFS_MASK);
  wire selCtrl = (regAddr == `SSL_OFS_CTRL);
  // out-of-range settings are clamped so the timers never exceed the range
  // compare the whole word: cutting first would wrap large values
  wire [7:0] delayIn = (regWdata > {8'h00, `SSL_MAX_REPLY_DLY}) ?
                       `SSL_MAX_REPLY_DLY : regWdata[7:0];
  wire [9:0] timeoutIn = (regWdata > {6'h00, `SSL_MAX_TIMEOUT}) ?
                         `SSL_MAX_TIMEOUT : regWdata[9:0];

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      replyDelay_ff <= `SSL_RST_REPLY_DLY;
      timeout_ff <= `SSL_RST_TIMEOUT;
      reaction_ff <= `SSL_RST_REACTION;
      writeReplyOff_ff <= `SSL_RST_WRREPLY;
      mask_ff <= 4'h0;
    end
    else if (regWr)
    begin
      if (selDelay)
        replyDelay_ff <= delayIn;
      if (selTimeout)
        timeout_ff <= timeoutIn;
      if (selReact)
        reaction_ff <= regWdata[1:0];
      if (selWrRep)
        writeReplyOff_ff <= regWdata[0];
      if (selMask)
        mask_ff <= regWdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // reply scheduling
  // ----------------------------------------------------------------
  ssl_pkg::ssl_rpl_e rpl_ff;
  ssl_pkg::ssl_rpl_e nxt_rpl;
  logic procSeen_ff;
  logic dlyDone;
  logic dlyRun;
  // a reply is owed unless broadcast or a suppressed write
  wire isBroadcast = (rxAddr == 8'h00);
  wire noReply = isBroadcast || (rxIsWrite && writeReplyOff_ff);
  wire frameIn = rxDone && rxGood;
  wire startReply = frameIn && !noReply;
  wire procNow = procSeen_ff || procDone;
  // programmed delay elapsed once the timer stops running after start
  wire dlyOver = dlyDone || (!dlyRun && rpl_ff == ssl_pkg::RPL_WAIT);

  ssl_tick_timer #(
    .TICK_CYCLES(MS_CYCLES),
    .CNT_W(8)
  ) u_reply_timer (
    .core_clk(core_clk),
    .srst(srst),
    .start(startReply),
    .load(replyDelay_ff),
    .expired(dlyDone),
    .running(dlyRun)
  );

  always_comb
  begin
    nxt_rpl = rpl_ff;
    case (rpl_ff)
      ssl_pkg::RPL_IDLE:
        if (startReply)
          nxt_rpl = ssl_pkg::RPL_WAIT;
      ssl_pkg::RPL_WAIT:
        // the later of the delay and the processing end releases the reply
        if (dlyOver && procNow)
          nxt_rpl = ssl_pkg::RPL_GO;
      ssl_pkg::RPL_GO:
        nxt_rpl = startReply ? ssl_pkg::RPL_WAIT : ssl_pkg::RPL_IDLE;
      default:
        nxt_rpl = ssl_pkg::RPL_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rpl_ff <= ssl_pkg::RPL_IDLE;
      procSeen_ff <= 1'b0;
    end
    else
    begin
      rpl_ff <= nxt_rpl;
      // processing may end in the very cycle the frame ends
      if (startReply)
        procSeen_ff <= procDone;
      else if (procDone)
        procSeen_ff <= 1'b1;
    end
  end

  assign replyGo = (rpl_ff == ssl_pkg::RPL_GO);
  assign replyDrop = frameIn && noReply;

  // ----------------------------------------------------------------
  // link timeout watchdog
  // ----------------------------------------------------------------
  logic toExpired;
  logic toRun;
  logic armed_ff;
  logic linkTimeout_ff;
  wire toEnabled = (timeout_ff != 10'h000);
  // restart on each good frame; a fresh enable also starts the watch
  wire toStart = toEnabled && (frameIn || !armed_ff);

  ssl_tick_timer #(
    .TICK_CYCLES(TENTH_CYCLES),
    .CNT_W(10)
  ) u_link_timer (
    .core_clk(core_clk),
    // disabling must also stop a watch already running
    .srst(srst || !toEnabled),
    .start(toStart),
    .load(timeout_ff),
    .expired(toExpired),
    .running(toRun)
  );

  always_ff @(posedge core_clk)
  begin
    if (srst || !toEnabled)
    begin
      armed_ff <= 1'b0;
      linkTimeout_ff <= 1'b0;
    end
    else
    begin
      armed_ff <= 1'b1;
      if (frameIn)
        linkTimeout_ff <= 1'b0;
      else if (toExpired)
        linkTimeout_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // link error reaction
  // ----------------------------------------------------------------
  logic linkErrEvt;
  logic alarm_ff;
  logic stop_ff;
  logic fltClear;
  ssl_pkg::ssl_react_e react;
  assign react = ssl_pkg::ssl_react_e'(reaction_ff);
  assign linkErrEvt = (rxDone && rxError) || toExpired;
  assign fltClear = regWr && selCtrl && regWdata[`SSL_CTRL_CLEAR];

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      alarm_ff <= 1'b0;
      stop_ff <= 1'b0;
    end
    else if (linkErrEvt)
    begin
      case (react)
        ssl_pkg::REACT_ALARM_COAST: alarm_ff <= 1'b1;
        ssl_pkg::REACT_KEEP_RUN: alarm_ff <= alarm_ff;
        ssl_pkg::REACT_STOP_LINKCMD: stop_ff <= stop_ff | runFromLink;
        ssl_pkg::REACT_STOP_ANY: stop_ff <= 1'b1;
        default: alarm_ff <= alarm_ff;
      endcase
    end
    else if (fltClear)
    begin
      alarm_ff <= 1'b0;
      stop_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // fault reporting and drive outputs
  // ----------------------------------------------------------------
  logic [15:0] code;
  logic anyFault;
  logic [15:0] code_ff;
  logic relay_ff;

  ssl_fault_coder u_coder (
    .faultIn(faultIn),
    .linkFault(alarm_ff),
    .code(code),
    .any(anyFault)
  );

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      code_ff <= `SSL_CODE_NONE;
      relay_ff <= 1'b0;
    end
    else
    begin
      code_ff <= code;
      relay_ff <= anyFault;
    end
  end

  assign faultCode = code_ff;
  assign faultRelay = relay_ff;
  // a fault removes drive output one cycle later through relay_ff, the motor coasts
  assign driveEnable = !relay_ff;
  assign stopRequest = stop_ff;
  assign linkAlarm = alarm_ff;

  // ----------------------------------------------------------------
  // interrupt status: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  wire [3:0] evt = {replyGo, anyFault && !relay_ff, toExpired,
                    rxDone && rxError};
  wire [3:0] w1c = (regWr && selStatus) ? regWdata[3:0] : 4'h0;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      status_ff <= 4'h0;
    else
      status_ff <= (status_ff & ~w1c) | evt;
  end

  assign irq = |(status_ff & mask_ff);

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [15:0] rdMux;
  always_comb
  begin
    case (regAddr)
      `SSL_OFS_REPLY_DLY: rdMux = {8'h00, replyDelay_ff};
      `SSL_OFS_TIMEOUT: rdMux = {6'h00, timeout_ff};
      `SSL_OFS_REACTION: rdMux = {14'h0000, reaction_ff};
      `SSL_OFS_WRREPLY: rdMux = {15'h0000, writeReplyOff_ff};
      `SSL_OFS_STATUS: rdMux = {12'h000, status_ff};
      `SSL_OFS_MASK: rdMux = {12'h000, mask_ff};
      `SSL_OFS_FAULT: rdMux = code_ff;
      `SSL_OFS_CTRL: rdMux = {13'h0000, linkTimeout_ff, stop_ff, alarm_ff};
      default: rdMux = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      rdata_ff <= 16'h0000;
    else if (regRd)
      rdata_ff <= rdMux;
    else
      rdata_ff <= 16'h0000;
  end

  assign regRdata = rdata_ff;
endmodule // ssl_link_supervisor

// [bench/ssl_link_checker.sv]
/*
  Port checker of the link supervisor, bound to it below.
  Assumes the register map of the defs header.
*/
`timescale 1ns/1ns
`include "ssl_defs.svh"
module ssl_link_checker #(
  parameter int MS_CYCLES = 4,
  parameter int TENTH_CYCLES = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  // frame and reply side
  input wire logic rxDone,
  input wire logic rxGood,
  input wire logic rxIsWrite,
  input wire logic [7:0] rxAddr,
  input wire logic procDone,
  input wire logic replyGo,
  input wire logic replyDrop,
  // drive side
  input wire logic [15:0] faultIn,
  input wire logic driveEnable,
  input wire logic stopRequest,
  input wire logic faultRelay,
  input wire logic [15:0] faultCode,
  input wire logic linkAlarm
);
  logic [7:0] dly_ff;
  logic [1:0] react_ff;
  logic wrSel_ff, pend_ff, proc_ff;
  int cnt_ff, rdy_ff;
  wire accept = rxDone && rxGood && rxAddr != 8'h00 && !(rxIsWrite && wrSel_ff);
  wire dlyOk = cnt_ff + 1 >= int'(dly_ff) * MS_CYCLES;

  // shadow of settings; mid-wait delay changes are not modelled
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      dly_ff <= `SSL_RST_REPLY_DLY;
      react_ff <= `SSL_RST_REACTION;
      wrSel_ff <= `SSL_RST_WRREPLY;
      pend_ff <= 1'b0;
      proc_ff <= 1'b0;
      cnt_ff <= 0;
      rdy_ff <= 0;
    end
    else
    begin
      if (regWr && regAddr == `SSL_OFS_REPLY_DLY)
        dly_ff <= (regWdata > 16'h00C8) ? `SSL_MAX_REPLY_DLY : regWdata[7:0];
      if (regWr && regAddr == `SSL_OFS_REACTION)
        react_ff <= regWdata[1:0];
      if (regWr && regAddr == `SSL_OFS_WRREPLY)
        wrSel_ff <= regWdata[0];
      pend_ff <= accept || (pend_ff && !replyGo);
      proc_ff <= accept ? procDone : (proc_ff || procDone);
      cnt_ff <= accept ? 0 : cnt_ff + 1;
      rdy_ff <= (pend_ff && proc_ff && dlyOk && !accept) ? rdy_ff + 1 : 0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_drop_rule: assert property (rxDone && rxGood |-> replyDrop == !accept)
    else $error("drop flag disagrees with frame kind");
  a_reply_hold: assert property (replyGo |-> dlyOk)
    else $error("reply before delay elapsed");
  a_reply_cause: assert property (replyGo |-> pend_ff && proc_ff)
    else $error("reply without accepted and processed frame");
  a_reply_bound: assert property (rdy_ff < 8)
    else $error("reply overdue");
  a_fault_trip: assert property ((faultIn != 16'h0000) [*3] |->
    faultRelay && !driveEnable)
    else $error("fault did not trip relay");
  a_code_first: assert property (faultIn[0] [*3] |-> faultCode == `SSL_CODE_UNDERV)
    else $error("undervoltage code wrong");
  a_code_link: assert property ((linkAlarm && faultIn == 16'h0000) [*3] |->
    faultCode == `SSL_CODE_LINK)
    else $error("link fault code wrong");
  a_alarm_react: assert property ($rose(linkAlarm) |-> react_ff == 2'h0)
    else $error("alarm under wrong reaction");
  a_stop_react: assert property ($rose(stopRequest) |-> react_ff[1])
    else $error("stop under wrong reaction");
  a_alarm_coast: assert property (linkAlarm [*2] |-> !driveEnable && faultRelay)
    else $error("alarm left drive on");

  c_reply: cover property (replyGo);
  c_alarm: cover property ($rose(linkAlarm));
  c_stop: cover property ($rose(stopRequest));
endmodule // ssl_link_checker

bind ssl_link_supervisor ssl_link_checker #(
  .MS_CYCLES(MS_CYCLES),
  .TENTH_CYCLES(TENTH_CYCLES)
) ssl_link_checker_inst (
  .core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .rxDone(rxDone), .rxGood(rxGood), .rxIsWrite(rxIsWrite),
  .rxAddr(rxAddr), .procDone(procDone), .replyGo(replyGo), .replyDrop(replyDrop),
  .faultIn(faultIn), .driveEnable(driveEnable), .stopRequest(stopRequest),
  .faultRelay(faultRelay), .faultCode(faultCode), .linkAlarm(linkAlarm)
);

// [bench/ssl_master_model.sv]
/*
  Far side model: frame decoder and request processing.
  Assumes frame() is called from one bench thread at a time.
*/
`timescale 1ns/1ns
module ssl_master_model (
  // clock
  input wire logic core_clk,
  // frame decoder side
  output logic rxDone,
  output logic rxGood,
  output logic rxError,
  output logic rxIsWrite,
  output logic [7:0] rxAddr,
  output logic procDone,
  // transmitter side
  input wire logic replyGo,
  input wire logic replyDrop
);
  initial
  begin
    {rxDone, rxGood, rxError, rxIsWrite, procDone} = 5'h00;
    rxAddr = 8'h5A;
  end

  // lat: edges from frame end to reply, -1 if none within span
  task automatic frame(input logic [7:0] a, input logic w, input logic e, input int pl,
    input int span, output int lat, output logic drp);
    lat = -1;
    @(posedge core_clk);
    rxDone <= 1'b1;
    rxGood <= !e;
    rxError <= e;
    rxIsWrite <= w;
    rxAddr <= a;
    procDone <= (pl == 0);
    #1 drp = replyDrop;
    for (int n = 1; n <= span; n++)
    begin
      @(posedge core_clk);
      rxDone <= 1'b0;
      // qualifiers mean nothing off rxDone: show the inverse, not a held value
      rxGood <= e;
      rxError <= !e;
      rxIsWrite <= !w;
      rxAddr <= ~a;
      procDone <= (n == pl);
      #1 if (replyGo === 1'b1 && lat < 0) lat = n;
    end
  endtask
endmodule // ssl_master_model

// [bench/test_serial_slave_link_supervisor.sv]
/*
  Self-checking bench of the link supervisor.
  Assumes short timing parameters so the watchdog fires in cycles.
*/
`timescale 1ns/1ns
`include "ssl_defs.svh"
module test_serial_slave_link_supervisor;
  localparam int MS = 4;
  localparam int TENTH = 10;
  logic core_clk, srst, regWr, regRd, runFromLink, rxDone, rxGood, rxError, rxIsWrite;
  logic procDone, replyGo, replyDrop, driveEnable, stopRequest, faultRelay, linkAlarm, irq;
  logic [3:0] regAddr;
  logic [7:0] rxAddr;
  logic [15:0] regWdata, regRdata, faultIn, faultCode;
  int n_fail = 0;
  int n_tests = 0;
  logic [15:0] rstVal [9] = '{16'h0005, 16'h0000, 16'h0001, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] codes [$] = '{`SSL_CODE_UNDERV, `SSL_CODE_OV_ACC, `SSL_CODE_OV_RUN,
    `SSL_CODE_OV_DEC, `SSL_CODE_OC_ACC, `SSL_CODE_OC_DEC, `SSL_CODE_OC_RUN,
    `SSL_CODE_MOTOR_OL, `SSL_CODE_DRIVE_OL, `SSL_CODE_STORAGE, `SSL_CODE_EXTERN,
    `SSL_CODE_OVERHEAT, `SSL_CODE_IN_PHASE, `SSL_CODE_OUT_PHASE, `SSL_CODE_SENSE,
    `SSL_CODE_LEARN};

  ssl_link_supervisor #(.MS_CYCLES(MS), .TENTH_CYCLES(TENTH)) ssl_link_supervisor_inst (
    .core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxDone(rxDone),
    .rxGood(rxGood), .rxError(rxError), .rxIsWrite(rxIsWrite), .rxAddr(rxAddr),
    .procDone(procDone), .replyGo(replyGo), .replyDrop(replyDrop),
    .runFromLink(runFromLink), .faultIn(faultIn), .driveEnable(driveEnable),
    .stopRequest(stopRequest), .faultRelay(faultRelay), .faultCode(faultCode),
    .linkAlarm(linkAlarm), .irq(irq));
  ssl_master_model ssl_master_model_inst (.core_clk(core_clk), .rxDone(rxDone),
    .rxGood(rxGood), .rxError(rxError), .rxIsWrite(rxIsWrite), .rxAddr(rxAddr),
    .procDone(procDone), .replyGo(replyGo), .replyDrop(replyDrop));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk("regRdata", exp & m, regRdata & m);
  endtask
  task automatic pause;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic test_done;
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (6000) @(posedge core_clk);
    n_fail++;
    test_done;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int lat, base, d, pl, i, r;
    logic drp;
    logic [15:0] f, e;
    {srst, regWr, regRd, runFromLink} = 4'h8;
    {regAddr, regWdata, faultIn} = 36'h0;
    void'($urandom(32'hCDDA));
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    // reset values, clamps, read-only and unmapped places
    for (i = 0; i < 9; i++)
      rd(4'(i), rstVal[i], 16'hFFFF);
    wr(`SSL_OFS_REPLY_DLY, 16'h00FF);
    rd(`SSL_OFS_REPLY_DLY, 16'h00C8, 16'hFFFF);
    wr(`SSL_OFS_TIMEOUT, 16'h07D0);
    rd(`SSL_OFS_TIMEOUT, 16'h03E8, 16'hFFFF);
    wr(`SSL_OFS_TIMEOUT, 16'h0000);
    wr(`SSL_OFS_FAULT, 16'hFFFF);
    wr(4'h9, 16'hFFFF);
    rd(`SSL_OFS_FAULT, 16'h0000, 16'hFFFF);
    rd(4'h9, 16'h0000, 16'hFFFF);
    // reply timing: programmed delay against processing time
    for (d = 0; d < 12; d += 4)
    begin
      for (pl = 0; pl <= 30; pl += 30)
      begin
        wr(`SSL_OFS_REPLY_DLY, 16'(d));
        ssl_master_model_inst.frame(8'($urandom_range(1, 255)), 1'b0, 1'b0, pl, 60, lat, drp);
        base = (d * MS > pl) ? d * MS : pl;
        chk("reply window", 16'h0001, 16'(lat > base && lat <= base + 6));
      end
    end
    // broadcast and write reply suppression
    wr(`SSL_OFS_REPLY_DLY, 16'h0000);
    for (i = 0; i < 4; i++)
    begin
      wr(`SSL_OFS_WRREPLY, 16'(i % 2));
      f = (i == 0) ? 16'h0000 : 16'($urandom_range(1, 255));
      ssl_master_model_inst.frame(f[7:0], 1'((i ^ (i >> 1)) & 1), 1'b0, 0, 40, lat, drp);
      chk("replyDrop", 16'(i < 2), 16'(drp));
      chk("replyGo", 16'(i >= 2), 16'(lat >= 0));
    end
    wr(`SSL_OFS_WRREPLY, 16'h0000);
    // link error reactions, status, mask and interrupt
    for (i = 0; i < 8; i++)
    begin
      r = i >> 1;
      wr(`SSL_OFS_REACTION, 16'(r));
      runFromLink <= 1'(i % 2);
      ssl_master_model_inst.frame(8'h05, 1'b0, 1'b1, 0, 4, lat, drp);
      chk("linkAlarm", 16'(r == 0), 16'(linkAlarm));
      chk("driveEnable", 16'(r != 0), 16'(driveEnable));
      chk("stopRequest", 16'(r == 3 || (r == 2 && i % 2 == 1)), 16'(stopRequest));
      rd(`SSL_OFS_STATUS, 16'h0001, 16'h0001);
      chk("irq", 16'h0000, 16'(irq));
      wr(`SSL_OFS_MASK, 16'h0001);
      pause;
      chk("irq", 16'h0001, 16'(irq));
      wr(`SSL_OFS_STATUS, 16'h0001);
      pause;
      chk("irq", 16'h0000, 16'(irq));
      wr(`SSL_OFS_CTRL, 16'h0001);
      wr(`SSL_OFS_MASK, 16'h0000);
      wr(`SSL_OFS_STATUS, 16'h000F);
      pause;
      chk("linkAlarm", 16'h0000, 16'(linkAlarm));
      chk("stopRequest", 16'h0000, 16'(stopRequest));
    end
    // link watchdog: traffic restarts it, quiet trips it, zero disables it
    wr(`SSL_OFS_REACTION, 16'h0000);
    wr(`SSL_OFS_TIMEOUT, 16'h0001);
    repeat (5) ssl_master_model_inst.frame(8'h07, 1'b0, 1'b0, 0, 4, lat, drp);
    rd(`SSL_OFS_STATUS, 16'h0008, 16'h000A);
    repeat (30) @(posedge core_clk);
    rd(`SSL_OFS_STATUS, 16'h0006, 16'h0006);
    rd(`SSL_OFS_CTRL, 16'h0005, 16'hFFFF);
    chk("faultCode", `SSL_CODE_LINK, faultCode);
    chk("faultRelay", 16'h0001, 16'(faultRelay));
    wr(`SSL_OFS_TIMEOUT, 16'h0000);
    wr(`SSL_OFS_CTRL, 16'h0001);
    wr(`SSL_OFS_STATUS, 16'h000F);
    repeat (40) @(posedge core_clk);
    rd(`SSL_OFS_STATUS, 16'h0000, 16'h0002);
    // fault codes: each source alone, then random mixes
    for (i = 0; i < 20; i++)
    begin
      f = (i < 16) ? (16'h0001 << i) : 16'($urandom_range(1, 65535));
      @(posedge core_clk);
      faultIn <= f;
      pause;
      e = `SSL_CODE_NONE;
      for (int k = 15; k >= 0; k--)
        if (f[k])
          e = codes[k];
      chk("faultCode", e, faultCode);
      chk("driveEnable", 16'h0000, 16'(driveEnable));
    end
    @(posedge core_clk);
    faultIn <= 16'h0000;
    pause;
    chk("faultCode", `SSL_CODE_NONE, faultCode);
    test_done;
  end
endmodule // test_serial_slave_link_supervisor
